// [logic/cocr_consts.vh]
// Constants for the clock output control register bank.
`ifndef COCR_CONSTS_VH
`define COCR_CONSTS_VH

// Register indices of the control bytes.
`define COCR_IDX_SREF_OE      3'h0
`define COCR_IDX_MISC_OE      3'h1
`define COCR_IDX_BUS_OE       3'h2
`define COCR_IDX_SREF_STOP    3'h3
`define COCR_IDX_STOP_PD      3'h4
`define COCR_IDX_DRIVE_MODE   3'h5
`define COCR_NUM_BYTES        7'h06
`define COCR_COUNT_BYTE       8'h06

// Power-up values of the control bytes.
`define COCR_RST_SREF_OE      8'hFF
`define COCR_RST_MISC_OE      8'hFE
`define COCR_RST_BUS_OE       8'hFF
`define COCR_RST_SREF_STOP    8'h00
`define COCR_RST_STOP_PD      8'h07
`define COCR_RST_DRIVE_MODE   8'h00

// Serial interface.
`define COCR_SLAVE_ADDR       8'hD2
`define COCR_CMD_BYTE_MODE    7
`define COCR_LAST_BIT         3'h7
// Idle levels of the synchronised pins: stops released, no power-down.
`define COCR_PIN_IDLE         5'h0F

// Field positions inside byte 1.
`define COCR_B1_BUS0_OE       7
`define COCR_B1_VIDEO_DOT_OE  6
`define COCR_B1_HOST48_OE     5
`define COCR_B1_REFERENCE_OUT0_OE       4
`define COCR_B1_REFERENCE_OUT1_OE       3
`define COCR_B1_PROC0_OE      1
`define COCR_B1_SPREAD        0

// Field positions inside bytes 2, 4 and 5.
`define COCR_B2_BUS1_OE       4
`define COCR_B2_PROC2_OE      1
`define COCR_B4_PANEL_PD_TRI  7
`define COCR_B4_DOT_PD_TRI    6
`define COCR_B4_BUS0_STOP     3
`define COCR_B5_SREF_STOP_TRI 7
`define COCR_B5_PROC_STOP_TRI 4
`define COCR_B5_SREF_PD_TRI   3

`endif

// [logic/cocr_sync.v]
// Two flip-flop synchroniser for asynchronous input levels.
`timescale 1ns/1ps
module cocr_sync #(
  parameter             WIDTH       = 1,
  parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
  // Clock and reset.
  input  wire             clk,
  input  wire             nrst,
  // Levels.
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta;

  // Both stages reset to the idle level of the pins, so no false edge or
  // false stop request is seen just after reset.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta     <= RESET_VALUE;
      sync_out <= RESET_VALUE;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule // cocr_sync

// [logic/cocr_top.v]
// Control bytes 0 to 5 of the clock synthesizer and their serial slave.
//
// Behaviour
// - Byte 0 bits 7..1 enable serial reference pairs 7..1, default on.
// - Byte 0 bit 0 enables shared pair 0 or panel pair, default on.
// - Byte 1 bits 7,5,4,3 enable bus0, host 48, reference_out0, reference_out1; default on.
// - Byte 1 bit 6 enables video non-spread and dot pair together.
// - Byte 1 bits 2 and 1 enable processor pairs 1 and 0.
// - Byte 1 bit 0 turns processor PLL spread on, default off.
// - Byte 2 bits 7..4 enable bus clocks 4..1, default on.
// - Byte 2 bit 1 enables processor pair 2, default on.
// - Byte 3 bit n lets bus stop halt serial reference pair n.
// - Byte 4 bits 7, 6 tri-state panel and dot pairs in power-down.
// - Byte 4 bit 3 lets bus stop halt free-running bus clock 0.
// - Byte 4 bits 2..0 let processor stop halt processor pairs.
// - Byte 5 bit 7 tri-states stopped serial reference pairs.
// - Byte 5 bits 6..4 tri-state stopped processor pairs 2..0.
// - Byte 5 bit 3 tri-states serial reference pairs 7..1 in power-down.
// - Byte 5 bits 2..0 tri-state processor pairs in power-down.
// - Command bit 7 picks byte or block; low bits give index.
// - Only the fixed slave address with direction bit is answered.
// - All control bytes load defaults at reset.
`timescale 1ns/1ps
`include "cocr_consts.vh"
module cocr_top (
  // Clock and reset.
  input  wire       CLK,
  input  wire       NRST,
  // Two-wire serial interface.
  input  wire       SCL,
  input  wire       SDA_IN,
  output reg        SDA_OUT,
  output reg        SDA_OE,
  // Clock control pins.
  input  wire       BUS_CLOCK_STOP_N,
  input  wire       PROCESSOR_CLOCK_STOP_N,
  input  wire       POWER_DOWN,
  // Serial reference pairs; pair 0 is shared with the panel pair.
  output reg  [7:0] SERIAL_REF_PAIR_OE,
  output reg  [7:0] SERIAL_REF_PAIR_RUN,
  // Processor clock pairs.
  output reg  [2:0] PROCESSOR_PAIR_OE,
  output reg  [2:0] PROCESSOR_PAIR_RUN,
  // Bus clocks; index 0 is the free-running bus clock.
  output reg  [4:0] BUS_CLOCK_OE,
  output reg  [4:0] BUS_CLOCK_RUN,
  // Video, dot, host port and reference clocks.
  output reg        VIDEO_CLOCK_NONSPREAD_OE,
  output reg        VIDEO_CLOCK_NONSPREAD_RUN,
  output reg        DOT_CLOCK_PAIR_OE,
  output reg        DOT_CLOCK_PAIR_RUN,
  output reg        HOST_PORT_CLOCK_48_OE,
  output reg        HOST_PORT_CLOCK_48_RUN,
  output reg  [1:0] REFERENCE_OUT_OE,
  output reg  [1:0] REFERENCE_OUT_RUN,
  // Processor PLL spread spectrum.
  output reg        PROCESSOR_PLL_SPREAD
);

  localparam [6:0] ST_IDLE = 7'h01;
  localparam [6:0] ST_ADDR = 7'h02;
  localparam [6:0] ST_CMD  = 7'h04;
  localparam [6:0] ST_CNT  = 7'h08;
  localparam [6:0] ST_WR   = 7'h10;
  localparam [6:0] ST_RD   = 7'h20;
  localparam [6:0] ST_MACK = 7'h40;

  wire [4:0] pins_sync;
  reg        scl_d, sda_d;
  reg  [6:0] state;
  reg  [7:0] shift;
  reg  [7:0] tx;
  reg  [2:0] cnt;
  reg  [6:0] idx;
  reg        blk;
  reg        ack_go, ack_on;
  reg  [7:0] ctl [0:5];
  integer    i;

  wire       scl_s      = pins_sync[0];
  wire       sda_s      = pins_sync[1];
  wire       bus_stop   = ~pins_sync[2];
  wire       proc_stop  = ~pins_sync[3];
  wire       pd         = pins_sync[4];
  wire       scl_rise   = scl_s & ~scl_d;
  wire       scl_fall   = ~scl_s & scl_d;
  wire       start_cond = scl_s & scl_d & sda_d & ~sda_s;
  wire       stop_cond  = scl_s & scl_d & ~sda_d & sda_s;
  wire [7:0] rx_byte    = {shift[6:0], sda_s};
  wire       idx_ok     = idx < `COCR_NUM_BYTES;
  wire [7:0] rd_byte    = idx_ok ? ctl[idx[2:0]] : 8'h00;
  wire [7:0] own_addr   = `COCR_SLAVE_ADDR;

  wire [7:0] b0 = ctl[`COCR_IDX_SREF_OE];
  wire [7:0] b1 = ctl[`COCR_IDX_MISC_OE];
  wire [7:0] b2 = ctl[`COCR_IDX_BUS_OE];
  wire [7:0] b3 = ctl[`COCR_IDX_SREF_STOP];
  wire [7:0] b4 = ctl[`COCR_IDX_STOP_PD];
  wire [7:0] b5 = ctl[`COCR_IDX_DRIVE_MODE];

  // Power-up value of each control byte.
  function [7:0] cocr_default;
    input [2:0] n;
    begin
      case (n)
        `COCR_IDX_SREF_OE:    cocr_default = `COCR_RST_SREF_OE;
        `COCR_IDX_MISC_OE:    cocr_default = `COCR_RST_MISC_OE;
        `COCR_IDX_BUS_OE:     cocr_default = `COCR_RST_BUS_OE;
        `COCR_IDX_SREF_STOP:  cocr_default = `COCR_RST_SREF_STOP;
        `COCR_IDX_STOP_PD:    cocr_default = `COCR_RST_STOP_PD;
        default:              cocr_default = `COCR_RST_DRIVE_MODE;
      endcase
    end
  endfunction

  // Returns {drive, toggle} for one output.
  function [1:0] cocr_gate;
    input en;
    input stop_sel;
    input stop_act;
    input stop_tri;
    input pd_act;
    input pd_tri;
    reg   halted;
    reg   tri_mode;
    begin
      halted   = pd_act | (stop_sel & stop_act);
      tri_mode = pd_act ? pd_tri : stop_tri;
      // A halted output that stays driven holds a static level.
      cocr_gate = {en & ~(halted & tri_mode), en & ~halted};
    end
  endfunction

  // Pins from outside the clock domain pass two flip-flops first.
  cocr_sync #(
    .WIDTH       (5),
    .RESET_VALUE (`COCR_PIN_IDLE)
  ) u_sync (
    .clk         (CLK),
    .nrst        (NRST),
    .async_in    ({POWER_DOWN, PROCESSOR_CLOCK_STOP_N, BUS_CLOCK_STOP_N,
                   SDA_IN, SCL}),
    .sync_out    (pins_sync)
  );

  // Serial slave: byte and block transfers on the control bytes.
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      scl_d   <= 1'b1;
      sda_d   <= 1'b1;
      state   <= ST_IDLE;
      shift   <= 8'h00;
      tx      <= 8'h00;
      cnt     <= 3'h0;
      idx     <= 7'h00;
      blk     <= 1'b0;
      ack_go  <= 1'b0;
      ack_on  <= 1'b0;
      SDA_OE  <= 1'b0;
      SDA_OUT <= 1'b0;
      for (i = 0; i < 6; i = i + 1) begin
        ctl[i] <= cocr_default(i[2:0]);
      end
    end else begin
      scl_d   <= scl_s;
      sda_d   <= sda_s;
      SDA_OUT <= 1'b0;
      if (start_cond) begin
        state  <= ST_ADDR;
        cnt    <= 3'h0;
        ack_go <= 1'b0;
        ack_on <= 1'b0;
        SDA_OE <= 1'b0;
      end else if (stop_cond) begin
        state  <= ST_IDLE;
        ack_go <= 1'b0;
        ack_on <= 1'b0;
        SDA_OE <= 1'b0;
      end else if (scl_rise && !ack_on) begin
        case (state)
          ST_ADDR, ST_CMD, ST_CNT, ST_WR: begin
            shift <= rx_byte;
            cnt   <= cnt + 3'h1;
            if (cnt == `COCR_LAST_BIT) begin
              case (state)
                ST_ADDR: begin
                  // Direction bit excluded from the compare.
                  if (rx_byte[7:1] == own_addr[7:1]) begin
                    ack_go <= 1'b1;
                    if (rx_byte[0]) begin
                      state <= ST_RD;
                      if (blk) begin
                        tx <= `COCR_COUNT_BYTE;
                      end else begin
                        tx  <= rd_byte;
                        idx <= idx + 7'h01;
                      end
                    end else begin
                      state <= ST_CMD;
                    end
                  end else begin
                    state <= ST_IDLE;
                  end
                end
                ST_CMD: begin
                  ack_go <= 1'b1;
                  blk    <= ~rx_byte[`COCR_CMD_BYTE_MODE];
                  if (rx_byte[`COCR_CMD_BYTE_MODE]) begin
                    idx   <= rx_byte[6:0];
                    state <= ST_WR;
                  end else begin
                    idx   <= 7'h00;
                    state <= ST_CNT;
                  end
                end
                ST_CNT: begin
                  // Block write count is taken but not enforced.
                  ack_go <= 1'b1;
                  state  <= ST_WR;
                end
                default: begin
                  ack_go <= 1'b1;
                  idx    <= idx + 7'h01;
                  if (idx_ok) begin
                    // Reserved bits stored as written, never decoded.
                    ctl[idx[2:0]] <= rx_byte;
                  end
                end
              endcase
            end
          end
          ST_RD: begin
            cnt <= cnt + 3'h1;
            if (cnt == `COCR_LAST_BIT) begin
              state <= ST_MACK;
            end
          end
          ST_MACK: begin
            if (sda_s) begin
              state <= ST_IDLE;
            end else begin
              state <= ST_RD;
              tx    <= rd_byte;
              idx   <= idx + 7'h01;
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end else if (scl_fall) begin
        if (ack_go) begin
          ack_go <= 1'b0;
          ack_on <= 1'b1;
          SDA_OE <= 1'b1;
        end else if (ack_on) begin
          ack_on <= 1'b0;
          cnt    <= 3'h0;
          if (state == ST_RD) begin
            SDA_OE <= ~tx[7];
            tx     <= {tx[6:0], 1'b0};
          end else begin
            SDA_OE <= 1'b0;
          end
        end else if (state == ST_RD) begin
          SDA_OE <= ~tx[7];
          tx     <= {tx[6:0], 1'b0};
        end else begin
          SDA_OE <= 1'b0;
        end
      end
    end
  end

  // Next output state, worked out from the control bytes and pins.
  reg  [7:0] next_sref_oe, next_sref_run;
  reg  [2:0] next_proc_oe, next_proc_run;
  reg  [4:0] next_bus_oe, next_bus_run;
  reg  [1:0] next_ref_oe, next_ref_run;
  reg  [1:0] next_video, next_dot, next_host, g;
  reg        proc_en, sref_pd_tri;
  integer    n;

  always @* begin
    g             = 2'h0;
    proc_en       = 1'b0;
    sref_pd_tri   = 1'b0;
    next_sref_oe  = 8'h00;
    next_sref_run = 8'h00;
    next_proc_oe  = 3'h0;
    next_proc_run = 3'h0;
    next_bus_oe   = 5'h00;
    next_bus_run  = 5'h00;
    next_ref_oe   = 2'h0;
    next_ref_run  = 2'h0;
    for (n = 0; n < 8; n = n + 1) begin
      // Pair 0 follows the panel power-down mode.
      sref_pd_tri = (n == 0) ? b4[`COCR_B4_PANEL_PD_TRI]
                             : b5[`COCR_B5_SREF_PD_TRI];
      g = cocr_gate(b0[n], b3[n], bus_stop,
                    b5[`COCR_B5_SREF_STOP_TRI], pd,
                    sref_pd_tri);
      next_sref_oe[n]  = g[1];
      next_sref_run[n] = g[0];
    end
    for (n = 0; n < 3; n = n + 1) begin
      proc_en = (n == 2) ? b2[`COCR_B2_PROC2_OE]
                         : b1[`COCR_B1_PROC0_OE + n];
      g = cocr_gate(proc_en, b4[n], proc_stop,
                    b5[`COCR_B5_PROC_STOP_TRI + n], pd,
                    b5[n]);
      next_proc_oe[n]  = g[1];
      next_proc_run[n] = g[0];
    end
    g = cocr_gate(b1[`COCR_B1_BUS0_OE], b4[`COCR_B4_BUS0_STOP],
                  bus_stop, 1'b0, pd, 1'b0);
    next_bus_oe[0]  = g[1];
    next_bus_run[0] = g[0];
    for (n = 1; n < 5; n = n + 1) begin
      g = cocr_gate(b2[`COCR_B2_BUS1_OE + n - 1], 1'b0, bus_stop,
                    1'b0, pd, 1'b0);
      next_bus_oe[n]  = g[1];
      next_bus_run[n] = g[0];
    end
    g = cocr_gate(b1[`COCR_B1_REFERENCE_OUT0_OE], 1'b0, 1'b0, 1'b0, pd, 1'b0);
    next_ref_oe[0]  = g[1];
    next_ref_run[0] = g[0];
    g = cocr_gate(b1[`COCR_B1_REFERENCE_OUT1_OE], 1'b0, 1'b0, 1'b0, pd, 1'b0);
    next_ref_oe[1]  = g[1];
    next_ref_run[1] = g[0];
    next_video = cocr_gate(b1[`COCR_B1_VIDEO_DOT_OE], 1'b0, 1'b0,
                           1'b0, pd, 1'b0);
    next_dot   = cocr_gate(b1[`COCR_B1_VIDEO_DOT_OE], 1'b0, 1'b0,
                           1'b0, pd, b4[`COCR_B4_DOT_PD_TRI]);
    next_host  = cocr_gate(b1[`COCR_B1_HOST48_OE], 1'b0, 1'b0,
                           1'b0, pd, 1'b0);
  end

  // Outputs are registered so the analog drivers see clean levels.
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      {SERIAL_REF_PAIR_OE, SERIAL_REF_PAIR_RUN, PROCESSOR_PAIR_OE,
       PROCESSOR_PAIR_RUN, BUS_CLOCK_OE, BUS_CLOCK_RUN, REFERENCE_OUT_OE,
       REFERENCE_OUT_RUN, VIDEO_CLOCK_NONSPREAD_OE, VIDEO_CLOCK_NONSPREAD_RUN,
       DOT_CLOCK_PAIR_OE, DOT_CLOCK_PAIR_RUN, HOST_PORT_CLOCK_48_OE,
       HOST_PORT_CLOCK_48_RUN, PROCESSOR_PLL_SPREAD} <= 43'h000_0000_0000;
    end else begin
      {SERIAL_REF_PAIR_OE, SERIAL_REF_PAIR_RUN, PROCESSOR_PAIR_OE,
       PROCESSOR_PAIR_RUN, BUS_CLOCK_OE, BUS_CLOCK_RUN, REFERENCE_OUT_OE,
       REFERENCE_OUT_RUN} <= {next_sref_oe, next_sref_run, next_proc_oe,
                              next_proc_run, next_bus_oe, next_bus_run,
                              next_ref_oe, next_ref_run};
      {VIDEO_CLOCK_NONSPREAD_OE, VIDEO_CLOCK_NONSPREAD_RUN} <= next_video;
      {DOT_CLOCK_PAIR_OE, DOT_CLOCK_PAIR_RUN} <= next_dot;
      {HOST_PORT_CLOCK_48_OE, HOST_PORT_CLOCK_48_RUN} <= next_host;
      PROCESSOR_PLL_SPREAD <= b1[`COCR_B1_SPREAD];
    end
  end

endmodule // cocr_top

// [tb/cocr_sva.sv]
// Port assertions for the clock output control bank.
`timescale 1ns/1ps
module cocr_sva (
  // Clock, reset and pins.
  input logic       CLK,
  input logic       NRST,
  input logic       SCL,
  input logic       SDA_OUT,
  input logic       SDA_OE,
  input logic       POWER_DOWN,
  // Clock outputs.
  input logic [7:0] SERIAL_REF_PAIR_OE,
  input logic [7:0] SERIAL_REF_PAIR_RUN,
  input logic [2:0] PROCESSOR_PAIR_OE,
  input logic [2:0] PROCESSOR_PAIR_RUN,
  input logic [4:0] BUS_CLOCK_OE,
  input logic [4:0] BUS_CLOCK_RUN,
  input logic       DOT_CLOCK_PAIR_RUN,
  input logic       HOST_PORT_CLOCK_48_OE,
  input logic       HOST_PORT_CLOCK_48_RUN,
  input logic [1:0] REFERENCE_OUT_RUN,
  input logic       PROCESSOR_PLL_SPREAD
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  // Pins cross a two-stage synchroniser, so four samples cover the lag.
  sequence pd_held; POWER_DOWN [*4]; endsequence
  sequence awake; !POWER_DOWN [*4]; endsequence
  reset_clear_a: assert property (
    $rose(NRST) |-> !SDA_OE && SERIAL_REF_PAIR_OE == 8'h00)
    else $error("outputs not clear at reset release");
  reset_default_a: assert property (
    $rose(NRST) |-> ##4 SERIAL_REF_PAIR_OE == 8'hFF &&
    PROCESSOR_PAIR_OE == 3'h7 && !PROCESSOR_PLL_SPREAD)
    else $error("defaults not shown after reset");
  sda_open_a: assert property (SDA_OUT == 1'b0)
    else $error("serial data driven high");
  sda_low_scl_a: assert property (
    $changed(SDA_OE) |-> !SCL) else $error("SDA moved with SCL high");
  ack_lag_a: assert property (
    $fell(SCL) |=> $stable(SDA_OE) [*2]) else $error("SDA moved early");
  pd_halt_a: assert property (
    pd_held |=> SERIAL_REF_PAIR_RUN == 8'h00 &&
    PROCESSOR_PAIR_RUN == 3'h0 && BUS_CLOCK_RUN == 5'h00)
    else $error("pair still running in power-down");
  pd_misc_a: assert property (
    pd_held |=> !DOT_CLOCK_PAIR_RUN && !HOST_PORT_CLOCK_48_RUN &&
    REFERENCE_OUT_RUN == 2'h0) else $error("clock runs in power-down");
  bus_free_a: assert property (
    awake |=> (BUS_CLOCK_RUN[4:1] & BUS_CLOCK_OE[4:1]) == BUS_CLOCK_OE[4:1])
    else $error("enabled bus clock halted");
  host_free_a: assert property (
    awake |=> !HOST_PORT_CLOCK_48_OE || HOST_PORT_CLOCK_48_RUN)
    else $error("enabled host clock halted");
endmodule // cocr_sva

bind cocr_top cocr_sva chk_u (.CLK, .NRST, .SCL, .SDA_OUT, .SDA_OE,
  .POWER_DOWN, .SERIAL_REF_PAIR_OE, .SERIAL_REF_PAIR_RUN,
  .PROCESSOR_PAIR_OE, .PROCESSOR_PAIR_RUN, .BUS_CLOCK_OE, .BUS_CLOCK_RUN,
  .DOT_CLOCK_PAIR_RUN, .HOST_PORT_CLOCK_48_OE, .HOST_PORT_CLOCK_48_RUN,
  .REFERENCE_OUT_RUN, .PROCESSOR_PLL_SPREAD);

// [tb/cocr_host.sv]
// Serial bus controller model on the two-wire pins.
`timescale 1ns/1ps
module cocr_host (
  // Clock and device pull-down.
  input  wire clk,
  input  wire dev_oe,
  // Pins.
  output reg  scl,
  output wire sda
);
  reg     low;
  integer hp;
  // Open drain with pull-up: a released line reads high.
  assign sda = !(low || dev_oe);
  initial begin
    low = 1'b0;
    scl = 1'b1;
    hp  = 8;
  end
  task ph;
    begin
      repeat (hp) @(posedge clk);
      #1;
    end
  endtask
  // Serves as first and repeated start alike.
  task start;
    begin
      low = 1'b0;
      ph;
      scl = 1'b1;
      ph;
      low = 1'b1;
      ph;
      scl = 1'b0;
      ph;
    end
  endtask
  task stop;
    begin
      low = 1'b1;
      ph;
      scl = 1'b1;
      ph;
      low = 1'b0;
      ph;
    end
  endtask
  // Data moves only a full phase after SCL falls.
  task bit_io(input b, output r);
    begin
      low = !b;
      ph;
      scl = 1'b1;
      ph;
      r = sda;
      scl = 1'b0;
      ph;
    end
  endtask
  task xfer(input [7:0] d, input last_b, output [7:0] q, output ack);
    integer i;
    reg     r;
    begin
      for (i = 7; i >= 0; i--) bit_io(d[i], q[i]);
      bit_io(last_b, r);
      ack = !r;
    end
  endtask
endmodule // cocr_host

// [tb/cocr_top_tb.sv]
// Self-checking bench for the clock output control bank.
`timescale 1ns/1ps
module cocr_top_tb;
  reg          clk;
  reg          nrst;
  reg          bsn;
  reg          psn;
  reg          pd;
  wire         scl;
  wire         sda;
  wire         sda_oe;
  wire         spr;
  wire  [20:0] oe_s;
  wire  [20:0] run_s;
  logic [7:0]  r [6];
  logic [7:0]  wq [$];
  integer      fails;
  integer      checked;
  integer      n;

  cocr_host host_u (.clk(clk), .dev_oe(sda_oe), .scl(scl), .sda(sda));
  cocr_top dut_u (.CLK(clk), .NRST(nrst), .SCL(scl), .SDA_IN(sda),
    .SDA_OUT(), .SDA_OE(sda_oe), .BUS_CLOCK_STOP_N(bsn),
    .PROCESSOR_CLOCK_STOP_N(psn), .POWER_DOWN(pd),
    .SERIAL_REF_PAIR_OE(oe_s[20:13]), .SERIAL_REF_PAIR_RUN(run_s[20:13]),
    .PROCESSOR_PAIR_OE(oe_s[12:10]), .PROCESSOR_PAIR_RUN(run_s[12:10]),
    .BUS_CLOCK_OE(oe_s[9:5]), .BUS_CLOCK_RUN(run_s[9:5]),
    .VIDEO_CLOCK_NONSPREAD_OE(oe_s[4]),
    .VIDEO_CLOCK_NONSPREAD_RUN(run_s[4]),
    .DOT_CLOCK_PAIR_OE(oe_s[3]), .DOT_CLOCK_PAIR_RUN(run_s[3]),
    .HOST_PORT_CLOCK_48_OE(oe_s[2]), .HOST_PORT_CLOCK_48_RUN(run_s[2]),
    .REFERENCE_OUT_OE(oe_s[1:0]), .REFERENCE_OUT_RUN(run_s[1:0]),
    .PROCESSOR_PLL_SPREAD(spr));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task cmp(input string nm, input logic [20:0] e, input logic [20:0] s);
    begin
      checked++;
      if (s !== e) begin
        fails++;
        $display("BAD %s exp %h got %h", nm, e, s);
      end
    end
  endtask

  task end_sim;
    begin
      $display("checked=%0d fails=%0d", checked, fails);
      if (fails == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  // Run is only meaningful for enabled outputs, so it is masked by enable.
  task chk_out;
    logic [20:0] eo;
    logic [20:0] en;
    logic [20:0] er;
    logic        st;
    integer      i;
    begin
      en = {r[0], r[2][1], r[1][2], r[1][1], r[2][7:4], r[1][7], r[1][6],
            r[1][6], r[1][5], r[1][3], r[1][4]};
      eo = en;
      er = {21{!pd}};
      for (i = 0; i < 8; i++) begin
        st = !bsn && r[3][i];
        if (st) er[13+i] = 1'b0;
        // The power-down mode bit outranks the stop mode bit.
        if (pd ? (i == 0 ? r[4][7] : r[5][3]) : (st && r[5][7]))
          eo[13+i] = 1'b0;
      end
      for (i = 0; i < 3; i++) begin
        st = !psn && r[4][i];
        if (st) er[10+i] = 1'b0;
        if (pd ? r[5][i] : (st && r[5][4+i])) eo[10+i] = 1'b0;
      end
      if (!bsn && r[4][3]) er[5] = 1'b0;
      if (pd && r[4][6]) eo[3] = 1'b0;
      cmp("oe", eo, oe_s);
      cmp("run", er & en, run_s & en);
      cmp("spread", r[1][0], spr);
    end
  endtask

  task wr(input [7:0] ad, input [7:0] cmd);
    logic [7:0] q;
    logic       a;
    integer     ix;
    begin
      ix = cmd[7] ? cmd[6:0] : 0;
      host_u.start;
      host_u.xfer(ad, 1'b1, q, a);
      cmp("ack", ad == 8'hD2, a);
      host_u.xfer(cmd, 1'b1, q, a);
      cmp("ack", ad == 8'hD2, a);
      if (!cmd[7]) host_u.xfer(8'h06, 1'b1, q, a);
      while (wq.size() > 0) begin
        host_u.xfer(wq[0], 1'b1, q, a);
        cmp("ack", ad == 8'hD2, a);
        if (ad == 8'hD2 && ix < 6) r[ix] = wq[0];
        void'(wq.pop_front());
        ix++;
      end
      host_u.stop;
    end
  endtask

  task rd(input [7:0] cmd, input integer cnt);
    logic [7:0] q;
    logic       a;
    integer     ix;
    integer     k;
    begin
      ix = cmd[7] ? cmd[6:0] : 0;
      host_u.start;
      host_u.xfer(8'hD2, 1'b1, q, a);
      host_u.xfer(cmd, 1'b1, q, a);
      host_u.start;
      host_u.xfer(8'hD3, 1'b1, q, a);
      cmp("ack", 1'b1, a);
      if (!cmd[7]) begin
        host_u.xfer(8'hFF, 1'b0, q, a);
        cmp("count", 8'h06, q);
      end
      for (k = 0; k < cnt; k++) begin
        host_u.xfer(8'hFF, k == cnt - 1, q, a);
        cmp("data", ix < 6 ? r[ix] : 8'h00, q);
        ix++;
      end
      host_u.stop;
    end
  endtask

  task do_reset;
    begin
      nrst = 1'b0;
      repeat (3) @(posedge clk);
      #1 nrst = 1'b1;
      r = '{8'hFF, 8'hFE, 8'hFF, 8'h00, 8'h07, 8'h00};
      repeat (8) @(posedge clk);
      #1;
    end
  endtask

  initial begin
    fails = 0;
    checked = 0;
    bsn = 1'b1;
    psn = 1'b1;
    pd = 1'b0;
    n = $urandom(18184);
    do_reset;
    chk_out;
    rd(8'h00, 6);
    for (n = 0; n < 24; n++) begin
      host_u.hp = (n % 2) ? 5 : 8;
      wq.push_back(8'($urandom));
      wr(8'hD2, 8'h80 | 8'($urandom % 8));
      {bsn, psn, pd} = 3'($urandom);
      repeat (8) @(posedge clk);
      #1 chk_out;
      {bsn, psn, pd} = 3'h6;
    end
    for (n = 0; n < 8; n++) rd(8'h80 | 8'(n), 1);
    for (n = 0; n < 6; n++) wq.push_back(8'($urandom));
    wr(8'hD2, 8'h00);
    rd(8'h82, 3);
    wq.push_back(8'h00);
    wr(8'hD4, 8'h81);
    rd(8'h00, 6);
    chk_out;
    do_reset;
    chk_out;
    rd(8'h00, 6);
    end_sim;
  end

  initial begin
    #800000;
    fails++;
    end_sim;
  end
endmodule // cocr_top_tb
